// >>> ccr_pkg.sv
// What this block does
// - phase delay: signed 10 bits, config 15:6
// - config bits 5:3 always read zero
// - bit 2 bypasses dc block, else global
// - bits 1:0 select input: pins/short/+test/-test
// - offset trim 24-bit signed, high register 23:8
// - offset low: bits 7:0 in 15:8, zero byte
// - gain trim 24-bit unsigned, high register 23:8
// - gain high resets to 8000h, unity gain
// - gain low: bits 7:0 in 15:8, zero byte
// - previous channel gain low laid out likewise
// - config at 22h, all fields reset zero
`default_nettype none

package ccr_pkg;

  // ==========================================================
  // register map
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] ADDR_PREV_GAIN_LOW = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_SETUP = 6'h22;
  localparam logic [ADDR_W-1:0] ADDR_OFS_HIGH = 6'h23;
  localparam logic [ADDR_W-1:0] ADDR_OFS_LOW = 6'h24;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_HIGH = 6'h25;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_LOW = 6'h26;

  // ==========================================================
  // field positions
  localparam int PHASE_MSB = 15;
  localparam int PHASE_LSB = 6;
  localparam int RSVD_MSB = 5;
  localparam int RSVD_LSB = 3;
  localparam int BYPASS_BIT = 2;
  localparam int SEL_MSB = 1;
  localparam int SEL_LSB = 0;
  localparam int LOW_MSB = 15;
  localparam int LOW_LSB = 8;

  // ==========================================================
  // reset values
  localparam logic [9:0] PHASE_RST = 10'h000;
  localparam logic BYPASS_RST = 1'b0;
  localparam logic [15:0] OFS_HIGH_RST = 16'h0000;
  localparam logic [7:0] OFS_LOW_RST = 8'h00;
  localparam logic [15:0] GAIN_HIGH_RST = 16'h8000;
  localparam logic [7:0] GAIN_LOW_RST = 8'h00;
  localparam logic [7:0] PREV_GAIN_LOW_RST = 8'h00;

  // ==========================================================
  // gain scaling: 24-bit gain, unity at bit 23
  localparam int GAIN_FRAC = 23;

  // input selection codes
  typedef enum logic [1:0] {
    CCR_SEL_PINS = 2'b00,
    CCR_SEL_SHORT = 2'b01,
    CCR_SEL_POS_TEST = 2'b10,
    CCR_SEL_NEG_TEST = 2'b11
  } ccr_sel_e;

  localparam ccr_sel_e SEL_RST = CCR_SEL_PINS;

endpackage : ccr_pkg

`default_nettype wire

// >>> ccr_channel_regs.sv
`default_nettype none

module ccr_channel_regs
  import ccr_pkg::*;
(
  input wire logic clk_sys, // device clock, 250 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [ADDR_W-1:0] regAddr, // register address
  input wire logic regWrEn, // one-cycle write strobe
  input wire logic [15:0] regWrData, // write data
  output logic [15:0] regRdData, // read data, one cycle late
  input wire logic globalDcBlockSetting, // global dc block on
  input wire logic signed [23:0] sampleIn, // raw converted sample
  input wire logic sampleInValid, // raw sample strobe
  output logic [9:0] channelPhaseDelay, // signed phase delay
  output logic channelDcBlockBypass, // per-channel bypass
  output logic channelDcBlockActive, // effective dc block
  output ccr_sel_e channelInputSelect, // input routing
  output logic [7:0] prevGainTrimLower, // previous channel gain 7:0
  output logic signed [23:0] sampleOut, // corrected sample
  output logic sampleOutValid // corrected sample strobe
);

  // ==========================================================
  // stored calibration state
  logic [15:0] offsetTrimUpper; // offset bits 23:8
  logic [7:0] offsetTrimLower; // offset bits 7:0
  logic [15:0] gainTrimUpper; // gain bits 23:8
  logic [7:0] gainTrimLower; // gain bits 7:0
  logic signed [23:0] offsetTrim; // assembled offset
  logic [23:0] gainTrim; // assembled gain

  // write decode
  logic wrSetup;
  logic wrOfsHigh;
  logic wrOfsLow;
  logic wrGainHigh;
  logic wrGainLow;
  logic wrPrevLow;

  assign wrSetup = regWrEn && (regAddr == ADDR_SETUP);
  assign wrOfsHigh = regWrEn && (regAddr == ADDR_OFS_HIGH);
  assign wrOfsLow = regWrEn && (regAddr == ADDR_OFS_LOW);
  assign wrGainHigh = regWrEn && (regAddr == ADDR_GAIN_HIGH);
  assign wrGainLow = regWrEn && (regAddr == ADDR_GAIN_LOW);
  assign wrPrevLow = regWrEn && (regAddr == ADDR_PREV_GAIN_LOW);

  // ==========================================================
  // channel setup register
  // setup fields; reserved bits are not stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      channelPhaseDelay <= PHASE_RST;
      channelDcBlockBypass <= BYPASS_RST;
      channelInputSelect <= SEL_RST;
    end else if (wrSetup) begin
      channelPhaseDelay <= regWrData[PHASE_MSB:PHASE_LSB];
      channelDcBlockBypass <= regWrData[BYPASS_BIT];
      channelInputSelect <= ccr_sel_e'(regWrData[SEL_MSB:SEL_LSB]);
    end
  end

  // bypass wins, otherwise follow the global setting
  assign channelDcBlockActive =
    globalDcBlockSetting && !channelDcBlockBypass;

  // ==========================================================
  // offset trim
  // upper and lower halves written independently
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      offsetTrimUpper <= OFS_HIGH_RST;
      offsetTrimLower <= OFS_LOW_RST;
    end else begin
      if (wrOfsHigh) begin
        offsetTrimUpper <= regWrData;
      end
      if (wrOfsLow) begin
        offsetTrimLower <= regWrData[LOW_MSB:LOW_LSB];
      end
    end
  end

  assign offsetTrim = {offsetTrimUpper, offsetTrimLower};

  // ==========================================================
  // gain trim, own and previous channel's lower byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gainTrimUpper <= GAIN_HIGH_RST;
      gainTrimLower <= GAIN_LOW_RST;
      prevGainTrimLower <= PREV_GAIN_LOW_RST;
    end else begin
      if (wrGainHigh) begin
        gainTrimUpper <= regWrData;
      end
      if (wrGainLow) begin
        gainTrimLower <= regWrData[LOW_MSB:LOW_LSB];
      end
      if (wrPrevLow) begin
        prevGainTrimLower <= regWrData[LOW_MSB:LOW_LSB];
      end
    end
  end

  assign gainTrim = {gainTrimUpper, gainTrimLower};

  // ==========================================================
  // read path
  // registered read; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else begin
      case (regAddr)
        ADDR_PREV_GAIN_LOW: regRdData <= {prevGainTrimLower, 8'h00};
        ADDR_SETUP: begin
          regRdData <= {channelPhaseDelay, 3'b000,
                        channelDcBlockBypass, channelInputSelect};
        end
        ADDR_OFS_HIGH: regRdData <= offsetTrimUpper;
        ADDR_OFS_LOW: regRdData <= {offsetTrimLower, 8'h00};
        ADDR_GAIN_HIGH: regRdData <= gainTrimUpper;
        ADDR_GAIN_LOW: regRdData <= {gainTrimLower, 8'h00};
        default: regRdData <= 16'h0000; // unmapped
      endcase
    end
  end

  // ==========================================================
  // sample correction
  logic signed [24:0] offsetSum; // sample plus offset
  logic signed [24:0] gainSigned; // gain, zero-extended
  logic signed [49:0] product; // full product
  logic signed [26:0] scaled; // product over 2^23
  logic signed [23:0] next_sampleOut; // saturated result

  // trims are read as they stand in the sample's cycle
  always_comb begin
    offsetSum = 25'(sampleIn) + 25'(offsetTrim);
    gainSigned = $signed({1'b0, gainTrim});
    product = offsetSum * gainSigned;
    scaled = product[GAIN_FRAC+26:GAIN_FRAC];
    if (scaled[26:23] == 4'h0 || scaled[26:23] == 4'hf) begin
      next_sampleOut = scaled[23:0]; // in range
    end else if (scaled[26]) begin
      next_sampleOut = 24'sh800000; // clip negative
    end else begin
      next_sampleOut = 24'sh7fffff; // clip positive
    end
  end

  // one-cycle registered result
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sampleOut <= 24'sh000000;
      sampleOutValid <= 1'b0;
    end else begin
      sampleOutValid <= sampleInValid;
      if (sampleInValid) begin
        sampleOut <= next_sampleOut;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_phase_write: assert property (
    wrSetup |=> channelPhaseDelay == $past(regWrData[15:6]))
    else $error("phase delay not taken from setup write");

  a_setup_rsvd_zero: assert property (
    !$past(rst) && $past(regAddr) == ADDR_SETUP |-> regRdData[5:3] == 3'b000)
    else $error("setup reserved bits read nonzero");

  a_dc_bypass: assert property (
    channelDcBlockBypass |-> !channelDcBlockActive)
    else $error("dc block active while bypassed");

  a_select_write: assert property (
    wrSetup ##1 !wrSetup [*2] |-> channelInputSelect == $past(regWrData[1:0], 2))
    else $error("input select lost after write");

  a_ofs_high_write: assert property (
    wrOfsHigh |=> offsetTrim[23:8] == $past(regWrData))
    else $error("offset upper bits not stored");

  // readback shows the byte as it stood when the address was sampled
  a_ofs_low_read: assert property (
    !$past(rst) && $past(regAddr) == ADDR_OFS_LOW |->
      regRdData == {$past(offsetTrim[7:0]), 8'h00})
    else $error("offset low readback wrong");

  a_gain_unity: assert property (@(posedge clk_sys)
    $past(rst) && !rst |-> gainTrim == 24'h800000)
    else $error("gain not unity after reset");

  a_gain_low_read: assert property (
    !$past(rst) && $past(regAddr) == ADDR_GAIN_LOW |->
      regRdData == {$past(gainTrim[7:0]), 8'h00})
    else $error("gain low readback wrong");

  a_prev_low_read: assert property (
    !$past(rst) && $past(regAddr) == ADDR_PREV_GAIN_LOW |->
      regRdData[7:0] == 8'h00)
    else $error("previous gain low byte nonzero");

  a_setup_reset: assert property (@(posedge clk_sys)
    $past(rst) && !rst |->
      channelPhaseDelay == 10'h000 && !channelDcBlockBypass &&
      channelInputSelect == CCR_SEL_PINS)
    else $error("setup fields not zero after reset");

  a_sample_unity: assert property (
    sampleInValid && gainTrim == 24'h800000 && offsetTrim == 24'h000000
      |=> sampleOutValid && sampleOut == $past(sampleIn))
    else $error("unity calibration altered the sample");

endmodule : ccr_channel_regs

`default_nettype wire

// >>> ccr_host_model.sv
`default_nettype none

// ==========================================================
// host side of the register port, one request at a time
module ccr_host_model
  import ccr_pkg::*;
(
  input wire logic clk_sys, // device clock
  output logic [ADDR_W-1:0] regAddr, // register address
  output logic regWrEn, // write strobe
  output logic [15:0] regWrData, // write data
  input wire logic [15:0] regRdData // read data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus from time zero
  initial begin
    regAddr = 6'h00;
    regWrEn = 1'b0;
    regWrData = 16'h0000;
  end

  // one-cycle write, changed at falling edges
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrEn = 1'b1;
    regWrData = d;
    @(negedge clk_sys);
    regWrEn = 1'b0;
    regWrData = ~d; // released data must not look valid
  endtask : wr

  // read data shows one edge after the address
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    @(negedge clk_sys);
    d = regRdData;
  endtask : rd
endmodule : ccr_host_model

`default_nettype wire

// >>> tb_channel_cal_config_regs.sv
`default_nettype none

`define CHK(n, e, a) begin checksDone++; if ((a) !== (e)) begin \
  failures++; $display("Error %s expected %h seen %h", n, e, a); end end

// ==========================================================
// register and sample path bench
module tb_channel_cal_config_regs
  import ccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0; // device clock
  logic rst = 1'b1; // synchronous reset
  logic [ADDR_W-1:0] regAddr; // from host
  logic regWrEn; // from host
  logic [15:0] regWrData; // from host
  logic [15:0] regRdData; // to host
  logic globalDcBlockSetting = 1'b0; // global dc block
  logic signed [23:0] sampleIn = 24'h000000; // raw sample
  logic sampleInValid = 1'b0; // raw strobe
  logic [9:0] channelPhaseDelay; // phase field
  logic channelDcBlockBypass; // bypass bit
  logic channelDcBlockActive; // effective dc block
  ccr_sel_e channelInputSelect; // input routing
  logic [7:0] prevGainTrimLower; // previous gain byte
  logic signed [23:0] sampleOut; // corrected sample
  logic sampleOutValid; // corrected strobe
  int failures = 0; // mismatches
  int checksDone = 0; // comparisons
  logic [15:0] rdVal; // last read
  logic [15:0] rstTab [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h8000, 16'h0000}; // reset values 21h..26h
  logic [15:0] maskTab [6] = '{16'hff00, 16'hffc7, 16'hffff, 16'hff00,
    16'hffff, 16'hff00}; // writable bits 21h..26h

  // 4 ns clock
  always #2 clk_sys = ~clk_sys;

  ccr_host_model host (.clk_sys(clk_sys), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData));

  ccr_channel_regs uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .globalDcBlockSetting(globalDcBlockSetting), .sampleIn(sampleIn),
    .sampleInValid(sampleInValid), .channelPhaseDelay(channelPhaseDelay),
    .channelDcBlockBypass(channelDcBlockBypass),
    .channelDcBlockActive(channelDcBlockActive),
    .channelInputSelect(channelInputSelect),
    .prevGainTrimLower(prevGainTrimLower), .sampleOut(sampleOut),
    .sampleOutValid(sampleOutValid));

  // verdict and end of run
  task endSim;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : endSim

  // read one register and compare
  task automatic chkReg(input logic [5:0] a, input logic [15:0] e);
    host.rd(a, rdVal);
    `CHK("regRdData", e, rdVal)
  endtask : chkReg

  // one raw sample in, corrected sample one edge later
  task automatic sample(input logic [23:0] v, input logic [23:0] e);
    @(negedge clk_sys);
    sampleIn = v;
    sampleInValid = 1'b1;
    @(negedge clk_sys);
    sampleInValid = 1'b0;
    sampleIn = ~v; // stale sample must not matter
    `CHK("sampleOutValid", 1'b1, sampleOutValid)
    `CHK("sampleOut", e, sampleOut)
  endtask : sample

  // watchdog against a hang
  initial begin
    #5000;
    failures++;
    endSim();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    for (int i = 0; i < 6; i++)
      chkReg(ADDR_PREV_GAIN_LOW + 6'(i), rstTab[i]);
    `CHK("phase", 10'h000, channelPhaseDelay)
    // unity gain and zero offset pass the sample unchanged
    sample(24'h923456, 24'h923456);
    // all ones: read-only bytes and bits stay zero
    for (int i = 0; i < 6; i++) begin
      host.wr(ADDR_PREV_GAIN_LOW + 6'(i), 16'hffff);
      chkReg(ADDR_PREV_GAIN_LOW + 6'(i), maskTab[i]);
    end
    `CHK("phase", 10'h3ff, channelPhaseDelay)
    `CHK("prevGain", 8'hff, prevGainTrimLower)
    host.wr(6'h20, 16'hffff);
    chkReg(6'h20, 16'h0000);
    // every input code, bypass and global setting combined
    for (int s = 0; s < 4; s++) begin
      host.wr(ADDR_SETUP, {10'h155, 3'b000, s[0], 2'(s)});
      globalDcBlockSetting = s[1];
      @(negedge clk_sys);
      `CHK("select", 2'(s), channelInputSelect)
      `CHK("bypass", s[0], channelDcBlockBypass)
      `CHK("dcActive", s[1] & ~s[0], channelDcBlockActive)
    end
    `CHK("phase", 10'h155, channelPhaseDelay)
    // offset 80h, gain one half
    host.wr(ADDR_OFS_HIGH, 16'h0000);
    host.wr(ADDR_OFS_LOW, 16'h8000);
    host.wr(ADDR_GAIN_HIGH, 16'h4000);
    host.wr(ADDR_GAIN_LOW, 16'h0000);
    sample(24'h000180, 24'h000100);
    sample(24'hfffe00, 24'hffff40);
    // largest gain drives the sum into saturation
    host.wr(ADDR_GAIN_HIGH, 16'hffff);
    host.wr(ADDR_GAIN_LOW, 16'hff00);
    sample(24'h7fffff, 24'h7fffff);
    // reset in mid-run brings every field back
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    chkReg(ADDR_GAIN_HIGH, 16'h8000);
    chkReg(ADDR_SETUP, 16'h0000);
    `CHK("prevGain", 8'h00, prevGainTrimLower)
    endSim();
  end
endmodule : tb_channel_cal_config_regs

`default_nettype wire
